// ---- src/tcc_pkg.sv ----
// constants, register map and field layouts of the timer capture/compare unit
package tcc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus, counter and prescaler widths, channel count
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned PRESCALE_FACTOR_W = 3;
  localparam int unsigned NUM_CH = 2;

  ////////////////////////////////////////////////////////////////////////////
  // register byte addresses, one aligned word each, data in bits 7:0
  localparam logic [ADDR_W-1:0] OFS_CTRL_A = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL_B = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CAP1_HI = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_CAP1_LO = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CAP2_HI = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_CAP2_LO = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_CMP1_HI = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_CMP1_LO = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_CMP2_HI = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_CMP2_LO = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_CNT_HI = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_CNT_LO = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_ALT_HI = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_ALT_LO = 8'h38;

  ////////////////////////////////////////////////////////////////////////////
  // counter, compare and capture values
  localparam logic [CNT_W-1:0] COUNT_RELOAD = 16'hFFFC;
  localparam logic [CNT_W-1:0] COUNT_MAX = 16'hFFFF;
  localparam logic [CNT_W-1:0] COUNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] COUNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] COMPARE_RESET = 16'h8000;
  localparam logic [CNT_W-1:0] CAPTURE_RESET = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // clock selection {clk_sel_hi, clk_sel_lo} and prescaler masks
  localparam logic [1:0] CLK_DIV4 = 2'h0;
  localparam logic [1:0] CLK_DIV2 = 2'h1;
  localparam logic [1:0] CLK_DIV8 = 2'h2;
  localparam logic [1:0] CLK_EXT = 2'h3;
  localparam logic [PRESCALE_FACTOR_W-1:0] PRESCALE_FACTOR_MASK_DIV2 = 3'h1;
  localparam logic [PRESCALE_FACTOR_W-1:0] PRESCALE_FACTOR_MASK_DIV4 = 3'h3;
  localparam logic [PRESCALE_FACTOR_W-1:0] PRESCALE_FACTOR_MASK_DIV8 = 3'h7;
  localparam logic [PRESCALE_FACTOR_W-1:0] PRESCALE_FACTOR_ZERO = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // register layouts
  typedef struct packed {
    logic capture_irq_en;
    logic compare_irq_en;
    logic overflow_irq_en;
    logic [1:0] spare;
    logic capture_edge_one;
    logic match_level_two;
    logic match_level_one;
  } tcc_ctrl_a_s;

  typedef struct packed {
    logic compare_pin_en_one;
    logic compare_pin_en_two;
    logic pwm_sel;
    logic single_pulse_sel;
    logic clk_sel_hi;
    logic clk_sel_lo;
    logic capture_edge_two;
    logic ext_edge_sel;
  } tcc_ctrl_b_s;

  typedef struct packed {
    logic capture_flag_one;
    logic compare_flag_one;
    logic overflow_flag;
    logic capture_flag_two;
    logic compare_flag_two;
    logic [2:0] spare;
  } tcc_status_s;

  localparam logic [BYTE_W-1:0] CTRL_A_RESET = 8'h00;
  localparam logic [BYTE_W-1:0] CTRL_B_RESET = 8'h00;
  localparam logic [BYTE_W-1:0] CTRL_A_WMASK = 8'hE7;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;

endpackage

// ---- src/tcc_timer_capture_compare.sv ----
// timer counter with two input capture and two output compare channels
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module tcc_timer_capture_compare (
  // clock, enable, reset
  input wire logic clk,
  input wire logic clk_en,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tcc_pkg::ADDR_W-1:0] paddr,
  input wire logic [tcc_pkg::DATA_W-1:0] pwdata,
  output logic [tcc_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins
  input wire logic ext_count_clk_pin,
  input wire logic capture_in_one,
  input wire logic capture_in_two,
  output logic compare_out_one,
  output logic compare_out_two,
  output logic compare_oe_one,
  output logic compare_oe_two,
  // cpu side
  input wire logic cpu_irq_mask,
  output logic timer_irq_req
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations
  tcc_pkg::tcc_ctrl_a_s ctrl_a_ff;
  tcc_pkg::tcc_ctrl_b_s ctrl_b_ff;
  tcc_pkg::tcc_status_s status_now;
  logic [tcc_pkg::DATA_W-1:0] prdata_ff;
  logic pready_ff, pslverr_ff, rd_sample, wr_commit, addr_hit;
  logic [tcc_pkg::BYTE_W-1:0] rd_byte, cnt_buf_ff;
  logic [tcc_pkg::CNT_W-1:0] cnt_ff;
  logic [tcc_pkg::PRESCALE_FACTOR_W-1:0] prescale_factor_ff, prescale_factor_mask;
  logic ext_s1_ff, ext_s2_ff, ext_prev_ff;
  logic int_tick, ext_tick, tick, tick_d_ff, cnt_reload;
  logic cnt_buf_valid_ff, ovf_flag_ff, ovf_arm_ff, cnt_lo_acc, status_rd, special_mode, irq_ff;
  logic [1:0] clk_sel, cap_pin, cap_edge_sel, pin_en, match_level;
  logic [tcc_pkg::CNT_W-1:0] cap_val_ff [tcc_pkg::NUM_CH], cmp_val_ff [tcc_pkg::NUM_CH];
  logic [1:0] cap_flag_ff, cmp_flag_ff, cmp_out_ff, cmp_oe_ff;

  //////////////////////////////////////////////////////////////////////////////
  // apb handshake: one wait state, read data sampled in the first access cycle
  assign rd_sample = clk_en & psel & penable & ~pready_ff & ~pwrite;
  assign wr_commit = clk_en & psel & penable & pready_ff & pwrite;
  assign status_rd = rd_sample & (paddr == tcc_pkg::OFS_STATUS);
  assign cnt_lo_acc = (rd_sample & (paddr == tcc_pkg::OFS_CNT_LO))
                    | (wr_commit & (paddr == tcc_pkg::OFS_CNT_LO));
  assign cnt_reload = wr_commit & ((paddr == tcc_pkg::OFS_CNT_LO)
                                 | (paddr == tcc_pkg::OFS_ALT_LO));

  always_comb begin
    status_now = '0;
    status_now.capture_flag_one = cap_flag_ff[0];
    status_now.capture_flag_two = cap_flag_ff[1];
    status_now.compare_flag_one = cmp_flag_ff[0];
    status_now.compare_flag_two = cmp_flag_ff[1];
    status_now.overflow_flag = ovf_flag_ff;
  end

  always_comb begin
    rd_byte = tcc_pkg::BYTE_ZERO;
    addr_hit = 1'b1;
    case (paddr)
      tcc_pkg::OFS_CTRL_A: rd_byte = ctrl_a_ff;
      tcc_pkg::OFS_CTRL_B: rd_byte = ctrl_b_ff;
      tcc_pkg::OFS_STATUS: rd_byte = status_now;
      tcc_pkg::OFS_CAP1_HI: rd_byte = cap_val_ff[0][15:8];
      tcc_pkg::OFS_CAP1_LO: rd_byte = cap_val_ff[0][7:0];
      tcc_pkg::OFS_CAP2_HI: rd_byte = cap_val_ff[1][15:8];
      tcc_pkg::OFS_CAP2_LO: rd_byte = cap_val_ff[1][7:0];
      tcc_pkg::OFS_CMP1_HI: rd_byte = cmp_val_ff[0][15:8];
      tcc_pkg::OFS_CMP1_LO: rd_byte = cmp_val_ff[0][7:0];
      tcc_pkg::OFS_CMP2_HI: rd_byte = cmp_val_ff[1][15:8];
      tcc_pkg::OFS_CMP2_LO: rd_byte = cmp_val_ff[1][7:0];
      tcc_pkg::OFS_CNT_HI, tcc_pkg::OFS_ALT_HI: rd_byte = cnt_ff[15:8];
      tcc_pkg::OFS_CNT_LO, tcc_pkg::OFS_ALT_LO: begin
        rd_byte = cnt_buf_valid_ff ? cnt_buf_ff : cnt_ff[7:0];
      end
      default: addr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else if (clk_en) begin
      if (psel && penable && !pready_ff) begin
        pready_ff <= 1'b1;
        pslverr_ff <= ~addr_hit;
        if (!pwrite) begin
          prdata_ff <= 32'(rd_byte);
        end
      end else begin
        pready_ff <= 1'b0;
        pslverr_ff <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_a_ff <= tcc_pkg::CTRL_A_RESET;
      ctrl_b_ff <= tcc_pkg::CTRL_B_RESET;
    end else if (wr_commit) begin
      if (paddr == tcc_pkg::OFS_CTRL_A) begin
        ctrl_a_ff <= pwdata[7:0] & tcc_pkg::CTRL_A_WMASK;
      end
      if (paddr == tcc_pkg::OFS_CTRL_B) begin
        ctrl_b_ff <= pwdata[7:0];
      end
    end
  end

  assign clk_sel = {ctrl_b_ff.clk_sel_hi, ctrl_b_ff.clk_sel_lo};
  assign special_mode = ctrl_b_ff.pwm_sel | ctrl_b_ff.single_pulse_sel;
  assign cap_pin = {capture_in_two, capture_in_one};
  assign cap_edge_sel = {ctrl_b_ff.capture_edge_two, ctrl_a_ff.capture_edge_one};
  assign pin_en = {ctrl_b_ff.compare_pin_en_two, ctrl_b_ff.compare_pin_en_one};
  assign match_level = {ctrl_a_ff.match_level_two, ctrl_a_ff.match_level_one};

  //////////////////////////////////////////////////////////////////////////////
  // timer clock: prescaler or synchronised external clock
  always_comb begin
    case (clk_sel)
      tcc_pkg::CLK_DIV2: prescale_factor_mask = tcc_pkg::PRESCALE_FACTOR_MASK_DIV2;
      tcc_pkg::CLK_DIV4: prescale_factor_mask = tcc_pkg::PRESCALE_FACTOR_MASK_DIV4;
      tcc_pkg::CLK_DIV8: prescale_factor_mask = tcc_pkg::PRESCALE_FACTOR_MASK_DIV8;
      default: prescale_factor_mask = tcc_pkg::PRESCALE_FACTOR_MASK_DIV4;
    endcase
  end

  assign int_tick = (prescale_factor_ff & prescale_factor_mask) == prescale_factor_mask;
  // the pin must hold each level for one cpu clock or an edge is lost
  assign ext_tick = (ext_s2_ff != ext_prev_ff) && (ext_s2_ff == ctrl_b_ff.ext_edge_sel);
  assign tick = (clk_sel == tcc_pkg::CLK_EXT) ? ext_tick : int_tick;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_s1_ff <= 1'b0;
      ext_s2_ff <= 1'b0;
      ext_prev_ff <= 1'b0;
    end else if (clk_en) begin
      ext_s1_ff <= ext_count_clk_pin;
      ext_s2_ff <= ext_s1_ff;
      ext_prev_ff <= ext_s2_ff;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prescale_factor_ff <= tcc_pkg::PRESCALE_FACTOR_ZERO;
      cnt_ff <= tcc_pkg::COUNT_RELOAD;
      tick_d_ff <= 1'b0;
    end else if (clk_en) begin
      tick_d_ff <= tick & ~cnt_reload;
      if (cnt_reload) begin
        prescale_factor_ff <= tcc_pkg::PRESCALE_FACTOR_ZERO;
        cnt_ff <= tcc_pkg::COUNT_RELOAD;
      end else begin
        prescale_factor_ff <= prescale_factor_ff + 3'(1);
        if (tick) begin
          cnt_ff <= cnt_ff + tcc_pkg::COUNT_ONE;
        end
      end
    end
  end

  // low byte is frozen by a high byte read until the low byte is read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_buf_ff <= tcc_pkg::BYTE_ZERO;
      cnt_buf_valid_ff <= 1'b0;
    end else if (rd_sample) begin
      if ((paddr == tcc_pkg::OFS_CNT_HI || paddr == tcc_pkg::OFS_ALT_HI)
          && !cnt_buf_valid_ff) begin
        cnt_buf_ff <= cnt_ff[7:0];
        cnt_buf_valid_ff <= 1'b1;
      end else if (paddr == tcc_pkg::OFS_CNT_LO || paddr == tcc_pkg::OFS_ALT_LO) begin
        cnt_buf_valid_ff <= 1'b0;
      end
    end
  end

  // overflow flag; only the main low byte clears it, not the alternate one
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ovf_flag_ff <= 1'b0;
      ovf_arm_ff <= 1'b0;
    end else if (clk_en) begin
      if (tick && !cnt_reload && cnt_ff == tcc_pkg::COUNT_MAX) begin
        ovf_flag_ff <= 1'b1;
      end else if (cnt_lo_acc && ovf_arm_ff) begin
        ovf_flag_ff <= 1'b0;
      end
      if (status_rd) begin
        ovf_arm_ff <= ovf_flag_ff;
      end else if (cnt_lo_acc) begin
        ovf_arm_ff <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // input capture channels
  for (genvar i = 0; i < tcc_pkg::NUM_CH; i++) begin : g_cap
    localparam logic [tcc_pkg::ADDR_W-1:0] HI = i ? tcc_pkg::OFS_CAP2_HI : tcc_pkg::OFS_CAP1_HI;
    localparam logic [tcc_pkg::ADDR_W-1:0] LO = i ? tcc_pkg::OFS_CAP2_LO : tcc_pkg::OFS_CAP1_LO;
    logic s1_ff, s2_ff, prev_ff;
    logic lock_ff, arm_ff, event_now, lo_acc;

    // channel one is taken by single pulse and pwm modes
    assign event_now = (s2_ff != prev_ff) && (s2_ff == cap_edge_sel[i])
                     && ((i != 0) || !special_mode);
    assign lo_acc = (rd_sample & (paddr == LO)) | (wr_commit & (paddr == LO));

    // pin is sampled regardless of its port direction
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        s1_ff <= 1'b0;
        s2_ff <= 1'b0;
        prev_ff <= 1'b0;
      end else if (clk_en) begin
        s1_ff <= cap_pin[i];
        s2_ff <= s1_ff;
        prev_ff <= s2_ff;
      end
    end

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        lock_ff <= 1'b0;
      end else if (rd_sample && paddr == HI) begin
        lock_ff <= 1'b1;
      end else if (rd_sample && paddr == LO) begin
        lock_ff <= 1'b0;
      end
    end

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        cap_val_ff[i] <= tcc_pkg::CAPTURE_RESET;
      end else if (clk_en && event_now && !lock_ff) begin
        cap_val_ff[i] <= cnt_ff;
      end
    end

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        cap_flag_ff[i] <= 1'b0;
        arm_ff <= 1'b0;
      end else if (clk_en) begin
        if (event_now) begin
          cap_flag_ff[i] <= 1'b1;
        end else if (lo_acc && arm_ff) begin
          cap_flag_ff[i] <= 1'b0;
        end
        if (status_rd) begin
          arm_ff <= cap_flag_ff[i];
        end else if (lo_acc) begin
          arm_ff <= 1'b0;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // output compare channels
  for (genvar i = 0; i < tcc_pkg::NUM_CH; i++) begin : g_cmp
    localparam logic [tcc_pkg::ADDR_W-1:0] HI = i ? tcc_pkg::OFS_CMP2_HI : tcc_pkg::OFS_CMP1_HI;
    localparam logic [tcc_pkg::ADDR_W-1:0] LO = i ? tcc_pkg::OFS_CMP2_LO : tcc_pkg::OFS_CMP1_LO;
    logic inhibit_ff, arm_ff, hit, lo_acc;
    logic [tcc_pkg::CNT_W-1:0] match_val;

    // slower clocks see the new counter value one count late
    assign match_val = (clk_sel == tcc_pkg::CLK_DIV2) ? cmp_val_ff[i]
                     : cmp_val_ff[i] + tcc_pkg::COUNT_ONE;
    assign hit = tick_d_ff && (cnt_ff == match_val) && !inhibit_ff;
    assign lo_acc = (rd_sample & (paddr == LO)) | (wr_commit & (paddr == LO));

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        cmp_val_ff[i] <= tcc_pkg::COMPARE_RESET;
        inhibit_ff <= 1'b0;
      end else if (wr_commit && paddr == HI) begin
        cmp_val_ff[i][15:8] <= pwdata[7:0];
        inhibit_ff <= 1'b1;
      end else if (wr_commit && paddr == LO) begin
        cmp_val_ff[i][7:0] <= pwdata[7:0];
        inhibit_ff <= 1'b0;
      end
    end

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        cmp_flag_ff[i] <= 1'b0;
        arm_ff <= 1'b0;
      end else if (clk_en) begin
        if (hit) begin
          cmp_flag_ff[i] <= 1'b1;
        end else if (lo_acc && arm_ff) begin
          cmp_flag_ff[i] <= 1'b0;
        end
        if (status_rd) begin
          arm_ff <= cmp_flag_ff[i];
        end else if (lo_acc) begin
          arm_ff <= 1'b0;
        end
      end
    end

    // pin latch starts low and only follows the level bit while enabled
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        cmp_out_ff[i] <= 1'b0;
        cmp_oe_ff[i] <= 1'b0;
      end else if (clk_en) begin
        cmp_oe_ff[i] <= pin_en[i];
        if (hit && pin_en[i]) begin
          cmp_out_ff[i] <= match_level[i];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupt request: flags stay set, so a masked request stays pending
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_ff <= 1'b0;
    end else if (clk_en) begin
      irq_ff <= ~cpu_irq_mask
              & ((ctrl_a_ff.capture_irq_en & (|cap_flag_ff))
              | (ctrl_a_ff.compare_irq_en & (|cmp_flag_ff))
              | (ctrl_a_ff.overflow_irq_en & ovf_flag_ff));
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign compare_out_one = cmp_out_ff[0];
  assign compare_out_two = cmp_out_ff[1];
  assign compare_oe_one = cmp_oe_ff[0];
  assign compare_oe_two = cmp_oe_ff[1];
  assign timer_irq_req = irq_ff;

endmodule

`default_nettype wire

// ---- testbench/tcc_chk.sv ----
// assertion checker for the timer capture/compare unit, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module tcc_chk (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tcc_pkg::ADDR_W-1:0] paddr,
  input wire logic [tcc_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins and cpu
  input wire logic compare_out_one,
  input wire logic compare_out_two,
  input wire logic compare_oe_one,
  input wire logic compare_oe_two,
  input wire logic cpu_irq_mask,
  input wire logic timer_irq_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no answer one cycle after access phase");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  chk_err_ready: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside an answer");
  chk_unmapped_err: assert property (pready && paddr > 8'h38 |-> pslverr)
    else $error("unmapped address answered without error");
  chk_read_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  chk_irq_mask: assert property (cpu_irq_mask |=> !timer_irq_req)
    else $error("interrupt request while cpu masked");
  chk_pin_rise_one: assert property ($rose(compare_out_one) |-> compare_oe_one)
    else $error("compare pin one rose while not enabled");
  chk_pin_rise_two: assert property ($rose(compare_out_two) |-> compare_oe_two)
    else $error("compare pin two rose while not enabled");
  chk_pin_quiet: assert property (!compare_oe_one && !$past(compare_oe_one)
    |-> $stable(compare_out_one))
    else $error("disabled compare pin one changed");
  chk_pin_quiet_two: assert property (!compare_oe_two && !$past(compare_oe_two)
    |-> $stable(compare_out_two))
    else $error("disabled compare pin two changed");
endmodule
bind tcc_timer_capture_compare tcc_chk u_chk (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .compare_out_one(compare_out_one), .compare_out_two(compare_out_two),
  .compare_oe_one(compare_oe_one), .compare_oe_two(compare_oe_two),
  .cpu_irq_mask(cpu_irq_mask), .timer_irq_req(timer_irq_req)
);
`default_nettype wire

// ---- testbench/tcc_pins.sv ----
// pin-side model: external count clock and capture event sources
`timescale 1ns/1ps
`default_nettype none
module tcc_pins (
  // clock
  input wire logic clk,
  // pins towards the timer
  output logic ext_count_clk_pin,
  output logic capture_in_one,
  output logic capture_in_two
);
  initial begin
    ext_count_clk_pin = 1'b0;
    capture_in_one = 1'b0;
    capture_in_two = 1'b0;
  end
  // every level is held at least seven cpu clocks, so edges are never closer than seven
  task automatic drive(input int unsigned pin, input logic v);
    @(posedge clk);
    case (pin)
      0: ext_count_clk_pin <= v;
      1: capture_in_one <= v;
      default: capture_in_two <= v;
    endcase
    repeat (6) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
// self-checking testbench of the timer capture/compare unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, reset_n, psel, penable, pwrite, cpu_irq_mask, pready, pslverr;
  logic [tcc_pkg::ADDR_W-1:0] paddr;
  logic [tcc_pkg::DATA_W-1:0] pwdata, prdata;
  logic ext_clk, cap1, cap2, out1, out2, irq, oe1, oe2, clk_en;
  logic [16:0] notes[$];
  logic [16:0] note;
  logic [15:0] rnd;
  int n_mismatch = 0;
  int check_count = 0;
  int seed = 32'h57fa;

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  tcc_timer_capture_compare dut (
    .clk(clk), .clk_en(clk_en), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_count_clk_pin(ext_clk), .capture_in_one(cap1),
    .capture_in_two(cap2), .compare_out_one(out1), .compare_out_two(out2),
    .compare_oe_one(oe1), .compare_oe_two(oe2), .cpu_irq_mask(cpu_irq_mask), .timer_irq_req(irq)
  );
  tcc_pins u_pins (.clk(clk), .ext_count_clk_pin(ext_clk), .capture_in_one(cap1),
    .capture_in_two(cap2));

  ////////////////////////////////////////////////////////////////////////////
  // notes are {mask, error, data}; a zero mask checks the error bit only
  task automatic cmp_resp(input logic [8:0] got, input logic [16:0] exp);
    check_count++;
    if (((got ^ exp[8:0]) & {1'b1, exp[16:9]}) !== 9'h0) begin
      n_mismatch++;
      $display("unexpected response at %0t: got %h expected %h", $time, got, exp[8:0]);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected pin at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [7:0] m);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    notes.push_back({m, a > 8'h38, d});
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    apb(1'b0, a, e, m);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 8'h00);
  endtask

  always @(posedge clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      note = notes.pop_front();
      cmp_resp({pslverr, prdata[7:0]}, note);
    end
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #400000;
    n_mismatch++;
    finish_test;
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    cpu_irq_mask = 1'b0;
    clk_en = 1'b1;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    rd(tcc_pkg::OFS_STATUS, 8'h00);
    rd(tcc_pkg::OFS_CTRL_A, 8'h00);
    rd(tcc_pkg::OFS_CTRL_B, 8'h00);
    rd(tcc_pkg::OFS_CAP1_HI, 8'h00);
    rd(tcc_pkg::OFS_CAP1_LO, 8'h00);
    rd(tcc_pkg::OFS_CMP1_HI, 8'h80);
    rd(tcc_pkg::OFS_CMP2_LO, 8'h00);
    rd(8'h3C, 8'h00, 8'h00);
    cmp_bit(out1, 1'b0);
    rnd = 16'($random(seed));
    wr(tcc_pkg::OFS_CMP1_HI, rnd[15:8]);
    wr(tcc_pkg::OFS_CMP1_LO, rnd[7:0]);
    rd(tcc_pkg::OFS_CMP1_HI, rnd[15:8]);
    rd(tcc_pkg::OFS_CMP1_LO, rnd[7:0]);
    $display("reset and register test done");
    // external clock, rising edges, capture one rising with interrupt
    wr(tcc_pkg::OFS_CTRL_B, 8'h0F);
    wr(tcc_pkg::OFS_CTRL_A, 8'h84);
    rd(tcc_pkg::OFS_STATUS, 8'h00, 8'h00);
    wr(tcc_pkg::OFS_CNT_LO, 8'h00);
    u_pins.drive(0, 1'b1);
    u_pins.drive(0, 1'b0);
    rd(tcc_pkg::OFS_CNT_HI, 8'hFF);
    rd(tcc_pkg::OFS_CNT_LO, 8'hFD);
    u_pins.drive(1, 1'b1);
    cmp_bit(irq, 1'b1);
    rd(tcc_pkg::OFS_STATUS, 8'h80, 8'hB0);
    rd(tcc_pkg::OFS_CAP1_HI, 8'hFF);
    u_pins.drive(0, 1'b1);
    u_pins.drive(1, 1'b0);
    u_pins.drive(1, 1'b1);
    rd(tcc_pkg::OFS_CAP1_LO, 8'hFD);
    u_pins.drive(2, 1'b1);
    wr(tcc_pkg::OFS_CAP2_HI, 8'hAA);
    rd(tcc_pkg::OFS_CAP2_HI, 8'hFF);
    rd(tcc_pkg::OFS_CAP2_LO, 8'hFE);
    u_pins.drive(0, 1'b0);
    u_pins.drive(0, 1'b1);
    u_pins.drive(0, 1'b0);
    u_pins.drive(0, 1'b1);
    rd(tcc_pkg::OFS_STATUS, 8'h30, 8'hB0);
    cmp_bit(irq, 1'b1);
    cpu_irq_mask <= 1'b1;
    repeat (3) @(posedge clk);
    cmp_bit(irq, 1'b0);
    cpu_irq_mask <= 1'b0;
    wr(tcc_pkg::OFS_CTRL_B, 8'h1F);
    u_pins.drive(1, 1'b0);
    u_pins.drive(1, 1'b1);
    rd(tcc_pkg::OFS_STATUS, 8'h00, 8'h80);
    $display("capture test done");
    // divide by two, compare one drives its pin, compare two held off
    wr(tcc_pkg::OFS_CTRL_A, 8'h43);
    wr(tcc_pkg::OFS_CTRL_B, 8'h84);
    wr(tcc_pkg::OFS_CMP1_HI, 8'h00);
    rd(tcc_pkg::OFS_STATUS, 8'h00, 8'h00);
    wr(tcc_pkg::OFS_CMP1_LO, 8'h10);
    wr(tcc_pkg::OFS_CMP2_HI, 8'h00);
    wr(tcc_pkg::OFS_CNT_LO, 8'h00);
    repeat (80) @(posedge clk);
    cmp_bit(out1, 1'b1);
    cmp_bit(out2, 1'b0);
    cmp_bit(irq, 1'b1);
    rd(tcc_pkg::OFS_STATUS, 8'h40, 8'h48);
    rd(tcc_pkg::OFS_CMP1_LO, 8'h10);
    rd(tcc_pkg::OFS_STATUS, 8'h00, 8'h40);
    cmp_bit(oe1, 1'b1);
    cmp_bit(oe2, 1'b0);
    $display("compare test done");
    // clock enable low freezes the counter, then divide by eight
    wr(tcc_pkg::OFS_CNT_LO, 8'h00);
    clk_en <= 1'b0;
    repeat (20) @(posedge clk);
    clk_en <= 1'b1;
    rd(tcc_pkg::OFS_CNT_HI, 8'hFF);
    rd(tcc_pkg::OFS_CNT_LO, 8'hFD);
    wr(tcc_pkg::OFS_CTRL_B, 8'h88);
    wr(tcc_pkg::OFS_CNT_LO, 8'h00);
    repeat (20) @(posedge clk);
    rd(tcc_pkg::OFS_CNT_HI, 8'hFF);
    rd(tcc_pkg::OFS_CNT_LO, 8'hFE);
    $display("clock enable and divide by eight test done");
    finish_test;
  end
endmodule
`default_nettype wire
